// >>> rtl/cfs_params.svh
// Constants for the converter fault supervisor: register indexes,
// fault bit positions, reset values and timing counts.
// Assumes a 40 MHz ref_clk_i and an APB byte address of index*4.
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
`define CFS_CLK_PERIOD_NS 25
`define CFS_MS_NS         1000000
`define CFS_CLKS_PER_MS   (`CFS_MS_NS / `CFS_CLK_PERIOD_NS)
`define CFS_OVLD_MS       16'h0064
`define CFS_PWRDN_MS      16'h01f4
`define CFS_ISL_FAULT     16'h0002
`define CFS_IX_RATED      16'h9d59
`define CFS_IX_AI_EN      16'h9dab
`define CFS_IX_HB         16'ha30c
`define CFS_IX_FLT_RST    16'ha30e
`define CFS_IX_WARN       16'ha31c
`define CFS_IX_FAULT      16'ha31e
`define CFS_IX_FACTORY    16'ha320
`define CFS_IX_UCFG_ERR   16'ha322
`define CFS_IX_TEMP       16'ha324
`define CFS_IX_AR_TO      16'ha361
`define CFS_IX_ISL_MODE   16'ha364
`define CFS_IX_HB_TO      16'ha36c
`define CFS_IX_AC_OC      16'ha38f
`define CFS_IX_AC_OV      16'ha392
`define CFS_IX_DC_UV      16'ha395
`define CFS_IX_DC_OV      16'ha398
`define CFS_IX_DC_OC      16'ha3aa
`define CFS_IX_GF_TRIP    16'ha3b1
`define CFS_IX_CTRL       16'ha400
`define CFS_IX_DATE       16'ha465
`define CFS_IX_TIME       16'ha467
`define CFS_FB_INV_OC     0
`define CFS_FB_AC_OV      1
`define CFS_FB_RT_LO      2
`define CFS_FB_ISLAND     6
`define CFS_FB_EMERGENCY_STOP_INPUT      7
`define CFS_FB_HB         8
`define CFS_FB_PWRDN      9
`define CFS_FB_DC_V       10
`define CFS_FB_DC_OC      11
`define CFS_FB_OVLD       12
`define CFS_FB_FACTORY    13
`define CFS_FF_ILK        7
`define CFS_DATE_RST      32'h010107d0
`define CFS_TIME_RST      32'h00000000
`endif

// >>> rtl/cfs_pkg.sv
// Types for the converter fault supervisor.
// Assumes cfs_params.svh holds the numeric constants.
package cfs_pkg;
   typedef enum logic [1:0] {ST_DISABLED, ST_RUN, ST_OFFLINE, ST_FAULT} cfs_state_e;
   typedef struct packed {
      logic [7:0]  day;
      logic [7:0]  month;
      logic [1:0]  unused;
      logic [13:0] year;
   } cfs_date_s;
   typedef struct packed {
      logic [7:0] unused;
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
   } cfs_time_s;
   typedef struct packed {
      logic [2:0][15:0] i_rms;
      logic [2:0][15:0] v_ll;
      logic [15:0]      dc_v;
      logic [15:0]      dc_i;
      logic [15:0]      rect_v;
      logic [15:0]      link_v;
   } cfs_meas_s;
endpackage : cfs_pkg

// >>> rtl/cfs_top.sv
// Converter fault supervisor: thresholds, timers, fault latch, APB slave.
// Assumes measurements come from logic on ref_clk_i; emergency_stop_input_i, bias_on_i and battery_low_i are synchronised here.
//
// Added by the designer: register access over APB.
`include "cfs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cfs_top #(
   parameter int unsigned TICK_CYC = `CFS_CLKS_PER_MS
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [17:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire cfs_pkg::cfs_meas_s meas_i,
   input  wire logic              emergency_stop_input_i,
   input  wire logic              bias_on_i,
   input  wire logic              battery_low_i,
   input  wire logic              run_req_i,
   input  wire logic              ac_close_req_i,
   input  wire logic              ac_contactor_closed_i,
   input  wire logic [3:0]        ride_through_trip_i,
   input  wire logic              grid_ok_i,
   input  wire logic              island_detect_i,
   input  wire logic              current_limit_active_i,
   input  wire logic              still_powered_i,
   input  wire logic [31:0]       factory_src_i,
   output logic                   power_stage_en_o,
   output logic                   ac_contactor_close_o,
   output logic                   dc_contactor_close_o,
   output logic                   fault_active_o,
   output logic [1:0]             converter_state_o
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      cfs_pkg::cfs_state_e state;
      logic [2:0]       s1;
      logic [2:0]       s2;
      logic [31:0]      tick_cnt;
      logic [15:0]      rated;
      logic [15:0]      ai_en;
      logic [15:0]      hb;
      logic [15:0]      ar_to;
      logic [15:0]      isl_mode;
      logic [15:0]      hb_to;
      logic [15:0]      ac_oc;
      logic [15:0]      ac_ov;
      logic [15:0]      dc_uv;
      logic [15:0]      dc_ov;
      logic [15:0]      dc_oc;
      logic [15:0]      gf_trip;
      logic [1:0]       ctrl;
      cfs_pkg::cfs_date_s date;
      cfs_pkg::cfs_time_s tod;
      logic [13:0]      fault;
      logic [31:0]      factory;
      logic             clk_warn;
      logic             hb_armed;
      logic [15:0]      hb_tmr;
      logic [15:0]      ar_tmr;
      logic [3:0]       rt_cause;
      logic [15:0]      ovl_tmr;
      logic [15:0]      pd_tmr;
      logic [2:0][15:0] gf_tmr;
      logic             pstage;
      logic             ac_cl;
      logic             dc_cl;
      logic             flt;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } cfs_regs_s;

   cfs_regs_s r;
   cfs_regs_s n;

   logic        tick;
   logic        acc;
   logic        wr;
   logic        fr;
   logic        hit;
   logic [15:0] idx;
   logic [31:0] rd;
   logic [13:0] cond;
   logic [31:0] fsrc;
   logic        ilk;
   logic        gf_on;
   logic        to_ev;
   logic        dt_bad;
   logic        emergency_stop_input_ok;
   logic        bias_on;
   logic        batt_low;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      // Pins pass two flops before use
      n.s1 = {emergency_stop_input_i, bias_on_i, battery_low_i};
      n.s2 = r.s1;
      emergency_stop_input_ok = r.s2[2];
      bias_on  = r.s2[1];
      batt_low = r.s2[0];
      tick = (r.tick_cnt >= TICK_CYC - 1);
      n.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;

      // APB slave, one wait state per access
      acc = psel_i & penable_i & ~r.pready;
      // Write commits on the edge the master sees pready
      wr  = psel_i & penable_i & r.pready & pwrite_i;
      idx = paddr_i[17:2];
      n.pready = acc;
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
      hit = 1'b1;
      rd = 32'h0;
      if (idx == `CFS_IX_RATED) begin
         rd = {16'h0, r.rated};
      end else if (idx == `CFS_IX_AI_EN) begin
         rd = {16'h0, r.ai_en};
      end else if (idx == `CFS_IX_HB) begin
         rd = {16'h0, r.hb};
      end else if (idx == `CFS_IX_FLT_RST) begin
         rd = 32'h0;
      end else if (idx == `CFS_IX_WARN) begin
         rd = {31'h0, r.clk_warn};
      end else if (idx == `CFS_IX_FAULT) begin
         rd = {18'h0, r.fault};
      end else if (idx == `CFS_IX_FACTORY) begin
         rd = r.factory;
      end else if (idx == `CFS_IX_UCFG_ERR || idx == `CFS_IX_TEMP) begin
         rd = 32'h0;
      end else if (idx == `CFS_IX_AR_TO) begin
         rd = {16'h0, r.ar_to};
      end else if (idx == `CFS_IX_ISL_MODE) begin
         rd = {16'h0, r.isl_mode};
      end else if (idx == `CFS_IX_HB_TO) begin
         rd = {16'h0, r.hb_to};
      end else if (idx == `CFS_IX_AC_OC) begin
         rd = {16'h0, r.ac_oc};
      end else if (idx == `CFS_IX_AC_OV) begin
         rd = {16'h0, r.ac_ov};
      end else if (idx == `CFS_IX_DC_UV) begin
         rd = {16'h0, r.dc_uv};
      end else if (idx == `CFS_IX_DC_OV) begin
         rd = {16'h0, r.dc_ov};
      end else if (idx == `CFS_IX_DC_OC) begin
         rd = {16'h0, r.dc_oc};
      end else if (idx == `CFS_IX_GF_TRIP) begin
         rd = {16'h0, r.gf_trip};
      end else if (idx == `CFS_IX_CTRL) begin
         rd = {30'h0, r.ctrl};
      end else if (idx == `CFS_IX_DATE) begin
         rd = r.date;
      end else if (idx == `CFS_IX_TIME) begin
         rd = r.tod;
      end else begin
         hit = 1'b0;
      end
      if (acc) begin
         n.pslverr = ~hit;
         n.prdata = pwrite_i ? 32'h0 : rd;
      end
      if (wr) begin
         if (idx == `CFS_IX_RATED) n.rated = pwdata_i[15:0];
         else if (idx == `CFS_IX_AI_EN) n.ai_en = pwdata_i[15:0];
         else if (idx == `CFS_IX_AR_TO) n.ar_to = pwdata_i[15:0];
         else if (idx == `CFS_IX_ISL_MODE) n.isl_mode = pwdata_i[15:0];
         else if (idx == `CFS_IX_HB_TO) n.hb_to = pwdata_i[15:0];
         else if (idx == `CFS_IX_AC_OC) n.ac_oc = pwdata_i[15:0];
         else if (idx == `CFS_IX_AC_OV) n.ac_ov = pwdata_i[15:0];
         else if (idx == `CFS_IX_DC_UV) n.dc_uv = pwdata_i[15:0];
         else if (idx == `CFS_IX_DC_OV) n.dc_ov = pwdata_i[15:0];
         else if (idx == `CFS_IX_DC_OC) n.dc_oc = pwdata_i[15:0];
         else if (idx == `CFS_IX_GF_TRIP) n.gf_trip = pwdata_i[15:0];
         else if (idx == `CFS_IX_CTRL) n.ctrl = pwdata_i[1:0];
         else if (idx == `CFS_IX_DATE) n.date = pwdata_i;
         else if (idx == `CFS_IX_TIME) n.tod = pwdata_i;
      end
      fr = wr && (idx == `CFS_IX_FLT_RST) && pwdata_i[0];

      // Heartbeat watchdog
      if (wr && idx == `CFS_IX_HB) begin
         n.hb = pwdata_i[15:0];
         n.hb_armed = 1'b1;
         if (!r.hb_armed || pwdata_i[15:0] == r.hb + 16'h1 || (pwdata_i[15:0] == 16'h0 && r.hb != 16'h0)) begin
            n.hb_tmr = 16'h0;
         end else if (tick && r.hb_tmr != 16'hffff) begin
            n.hb_tmr = r.hb_tmr + 16'h1;
         end
      end else if (tick && r.hb_armed && r.hb_tmr != 16'hffff) begin
         n.hb_tmr = r.hb_tmr + 16'h1;
      end

      gf_on = r.ctrl[0] && r.state == cfs_pkg::ST_RUN;
      for (int p = 0; p < 3; p++) begin
         if (!gf_on) begin
            n.gf_tmr[p] = 16'h0;
         end else if (tick && meas_i.i_rms[p] > r.rated) begin
            if (r.gf_tmr[p] != 16'hffff) n.gf_tmr[p] = r.gf_tmr[p] + 16'h1;
         end else if (tick && r.gf_tmr[p] != 16'h0) begin
            n.gf_tmr[p] = r.gf_tmr[p] - 16'h1;
         end
      end

      if (!current_limit_active_i) n.ovl_tmr = 16'h0;
      else if (tick && r.ovl_tmr < `CFS_OVLD_MS) n.ovl_tmr = r.ovl_tmr + 16'h1;
      if (bias_on || !still_powered_i) n.pd_tmr = 16'h0;
      else if (tick && r.pd_tmr < `CFS_PWRDN_MS) n.pd_tmr = r.pd_tmr + 16'h1;

      to_ev = r.state == cfs_pkg::ST_OFFLINE && !grid_ok_i && r.ar_tmr >= r.ar_to;
      ilk = ac_close_req_i && meas_i.rect_v > meas_i.link_v;

      cond = 14'h0;
      for (int p = 0; p < 3; p++) begin
         if (meas_i.i_rms[p] > r.ac_oc) cond[`CFS_FB_INV_OC] = 1'b1;
         if (gf_on && r.gf_tmr[p] > r.gf_trip) cond[`CFS_FB_INV_OC] = 1'b1;
         if (ac_contactor_closed_i && meas_i.v_ll[p] > r.ac_ov) cond[`CFS_FB_AC_OV] = 1'b1;
      end
      cond[`CFS_FB_RT_LO +: 4] = to_ev ? r.rt_cause : 4'h0;
      cond[`CFS_FB_ISLAND] = island_detect_i && r.ai_en[0] && r.isl_mode == `CFS_ISL_FAULT;
      cond[`CFS_FB_EMERGENCY_STOP_INPUT] = ~emergency_stop_input_ok;
      cond[`CFS_FB_HB] = r.hb_armed && r.hb_tmr >= r.hb_to;
      cond[`CFS_FB_PWRDN] = r.pd_tmr >= `CFS_PWRDN_MS;
      cond[`CFS_FB_DC_V] = meas_i.dc_v > r.dc_ov || meas_i.dc_v < r.dc_uv;
      cond[`CFS_FB_DC_OC] = meas_i.dc_i > r.dc_oc;
      cond[`CFS_FB_OVLD] = r.ovl_tmr >= `CFS_OVLD_MS;
      fsrc = factory_src_i;
      fsrc[`CFS_FF_ILK] = fsrc[`CFS_FF_ILK] | ilk;
      n.factory = fr ? fsrc : (r.factory | fsrc);
      cond[`CFS_FB_FACTORY] = |n.factory;
      // latch; reset only drops gone causes
      n.fault = fr ? cond : (r.fault | cond);

      dt_bad = r.date.day == 8'h0 || r.date.day > 8'h1f || r.date.month == 8'h0
               || r.date.month > 8'h0c || r.tod.seconds > 8'h3b || r.tod.minutes > 8'h3b
               || r.tod.hours > 8'h17;
      n.clk_warn = r.clk_warn | batt_low | dt_bad;

      if (tick && r.ar_tmr != 16'hffff) n.ar_tmr = r.ar_tmr + 16'h1;
      case (r.state)
         cfs_pkg::ST_DISABLED: begin
            if (run_req_i) n.state = cfs_pkg::ST_RUN;
         end
         cfs_pkg::ST_RUN: begin
            if (!run_req_i) begin
               n.state = cfs_pkg::ST_DISABLED;
            end else if (r.ctrl[1] && |ride_through_trip_i) begin
               n.state = cfs_pkg::ST_OFFLINE;
               n.rt_cause = ride_through_trip_i;
               n.ar_tmr = 16'h0;
            end
         end
         cfs_pkg::ST_OFFLINE: begin
            if (grid_ok_i) n.state = cfs_pkg::ST_RUN;
         end
         default: begin
            if (fr) n.state = cfs_pkg::ST_DISABLED;
         end
      endcase
      if (|n.fault) n.state = cfs_pkg::ST_FAULT;

      n.pstage = n.state == cfs_pkg::ST_RUN;
      n.dc_cl = n.state == cfs_pkg::ST_RUN || n.state == cfs_pkg::ST_OFFLINE;
      n.ac_cl = n.state == cfs_pkg::ST_RUN && ac_close_req_i && !ilk;
      n.flt = |n.fault;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
         r.state <= cfs_pkg::ST_DISABLED;
         r.date <= `CFS_DATE_RST;
         r.tod <= `CFS_TIME_RST;
         // Power-on treats emergency_stop_input as high, with no stop flagged, until sampled
         r.s1[2] <= 1'b1;
         r.s2[2] <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prdata_o             = r.prdata;
   assign pready_o             = r.pready;
   assign pslverr_o            = r.pslverr;
   assign power_stage_en_o     = r.pstage;
   assign ac_contactor_close_o = r.ac_cl;
   assign dc_contactor_close_o = r.dc_cl;
   assign fault_active_o       = r.flt;
   assign converter_state_o    = r.state;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   AST_EMERGENCY_STOP_INPUT: assert property (!r.s2[2] |=> r.fault[`CFS_FB_EMERGENCY_STOP_INPUT]) else $error("emergency_stop_input fault missing");
   AST_DC_OC: assert property (meas_i.dc_i > r.dc_oc |=> r.fault[`CFS_FB_DC_OC]) else $error("dc oc missing");
   AST_DC_V: assert property ((meas_i.dc_v > r.dc_ov || meas_i.dc_v < r.dc_uv) |=> r.fault[`CFS_FB_DC_V])
      else $error("dc voltage fault missing");
   AST_AC_OV: assert property ((ac_contactor_closed_i && meas_i.v_ll[0] > r.ac_ov) |=> r.fault[`CFS_FB_AC_OV])
      else $error("ac ov fault missing");
   AST_SAFE: assert property (r.flt |-> !power_stage_en_o && !ac_contactor_close_o && !dc_contactor_close_o)
      else $error("outputs on during fault");
   AST_HB_DISARM: assert property (!r.hb_armed |-> !r.fault[`CFS_FB_HB]) else $error("hb fault unarmed");
   AST_ISLAND: assert property ((island_detect_i && r.ai_en[0] && r.isl_mode == `CFS_ISL_FAULT)
      |=> r.fault[`CFS_FB_ISLAND]) else $error("island fault missing");
   AST_HB_SAME: assert property ((wr && idx == `CFS_IX_HB && r.hb_armed && pwdata_i[15:0] == r.hb
      && r.hb_tmr != 16'h0) |=> r.hb_tmr != 16'h0) else $error("hb repeat restarted");
   AST_FACTORY: assert property (|r.factory |-> r.fault[`CFS_FB_FACTORY]) else $error("factory summary");
   AST_ILK: assert property (ilk |=> !ac_contactor_close_o ##0 r.factory[`CFS_FF_ILK]) else $error("interlock");

   COV_FAULT: cover property (!r.flt ##1 r.flt);
   COV_OFFLINE: cover property (r.state == cfs_pkg::ST_OFFLINE ##1 r.state == cfs_pkg::ST_RUN);
   COV_RESET: cover property (r.state == cfs_pkg::ST_FAULT ##1 r.state == cfs_pkg::ST_DISABLED);

endmodule : cfs_top
`default_nettype wire

// >>> test/cfs_ctrl_model.sv
// System controller model: APB master and heartbeat sequencing.
// Assumes the bench calls its tasks; waits for pready, never a fixed count.
`include "cfs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfs_ctrl_model (
   input  wire logic        ref_clk_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [17:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   logic [15:0] hb_last;
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 18'h0;
      pwdata_o = 32'h0;
      hb_last = 16'h0;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [15:0] ix, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge ref_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= {ix, 2'b00};
      pwdata_o <= d;
      @(posedge ref_clk_i);
      penable_o <= 1'b1;
      // Only the bench timeout ends a stuck wait
      do begin
         @(posedge ref_clk_i);
      end while (pready_i !== 1'b1);
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Released data is not a stable value
      pwdata_o <= ~d;
   endtask : xfer
   ////////////////////////////////////////////////////////////////////
   // plus one, repeat, or zero
   task automatic hb(input logic [1:0] mode);
      logic [31:0] q;
      logic        e;
      if (mode == 2'h1) hb_last = hb_last + 16'h1;
      else if (mode == 2'h2) hb_last = 16'h0;
      xfer(1'b1, `CFS_IX_HB, {16'h0, hb_last}, q, e);
   endtask : hb
endmodule : cfs_ctrl_model
`default_nettype wire

// >>> test/cfs_tb_top.sv
// Self-checking bench for the converter fault supervisor.
// Assumes TICK_CYC of 4 so that every ms timer is four clocks.
`include "cfs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfs_tb_top;
   logic               ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
   logic [17:0]        paddr;
   logic [31:0]        pwdata, prdata, rq, fsrc;
   logic               re, emergency_stop_input, bias_on, bat_low, run_req, ac_req, ac_closed, grid_ok;
   logic               island, climit, still_pwr, pwr_en, ac_cl, dc_cl, flt_act;
   logic [3:0]         rt_trip;
   logic [1:0]         st;
   cfs_pkg::cfs_meas_s meas;
   int                 error_cnt, checked;
   int                 cyc = 0;
   cfs_top #(.TICK_CYC(4)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .meas_i(meas), .emergency_stop_input_i(emergency_stop_input), .bias_on_i(bias_on),
      .battery_low_i(bat_low), .run_req_i(run_req), .ac_close_req_i(ac_req), .ac_contactor_closed_i(ac_closed),
      .ride_through_trip_i(rt_trip), .grid_ok_i(grid_ok), .island_detect_i(island),
      .current_limit_active_i(climit), .still_powered_i(still_pwr), .factory_src_i(fsrc),
      .power_stage_en_o(pwr_en), .ac_contactor_close_o(ac_cl), .dc_contactor_close_o(dc_cl),
      .fault_active_o(flt_act), .converter_state_o(st));
   cfs_ctrl_model ctrl_u (.ref_clk_i(ref_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
   ////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // Hang guard, well above the longest sequence
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         error_cnt++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] ix, input logic [31:0] d);
      ctrl_u.xfer(1'b1, ix, d, rq, re);
   endtask : wr
   task automatic rd(input logic [15:0] ix);
      ctrl_u.xfer(1'b0, ix, 32'h0, rq, re);
   endtask : rd
   task automatic cw(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : cw
   task automatic fault_is(input logic [31:0] exp, input string what);
      rd(`CFS_IX_FAULT);
      chk(rq, exp, what);
   endtask : fault_is
   task automatic tripped(input int b, input string what);
      cw(4);
      fault_is(32'h1 << b, what);
      chk({26'h0, st, flt_act, pwr_en, ac_cl, dc_cl}, 32'h38, "fault outputs");
   endtask : tripped
   task automatic clr(input string name);
      wr(`CFS_IX_FLT_RST, 32'h1);
      cw(2);
      fault_is(32'h0, "cleared");
      chk({30'h0, st}, 32'h0, "state after clear");
      $display("test %s done", name);
   endtask : clr
   ////////////////////////////////////////////////////////////////////
   initial begin
      error_cnt = 0;
      checked = 0;
      rst_i = 1'b1;
      meas = '0;
      {emergency_stop_input, bias_on, bat_low, run_req, ac_req, ac_closed, grid_ok} = 7'b1100000;
      {island, climit, still_pwr, rt_trip, fsrc} = '0;
      cw(20);
      rst_i <= 1'b0;
      rd(`CFS_IX_DATE);
      chk(rq, `CFS_DATE_RST, "date reset");
      wr(`CFS_IX_DATE, {8'h0f, 8'h06, 2'h0, 14'h07e8});
      rd(`CFS_IX_DATE);
      chk(rq, 32'h0f0607e8, "date word");
      wr(`CFS_IX_TIME, {8'h00, 8'h1e, 8'h2d, 8'h0c});
      rd(`CFS_IX_TIME);
      chk(rq, 32'h001e2d0c, "time word");
      rd(16'h0001);
      chk({31'h0, re}, 32'h1, "unmapped error");
      chk(rq, 32'h0, "unmapped data");
      wr(`CFS_IX_AC_OC, 32'h3e8);
      wr(`CFS_IX_AC_OV, 32'h3e8);
      wr(`CFS_IX_DC_UV, 32'h64);
      wr(`CFS_IX_DC_OV, 32'h384);
      wr(`CFS_IX_DC_OC, 32'h1f4);
      wr(`CFS_IX_RATED, 32'h12c);
      wr(`CFS_IX_GF_TRIP, 32'h3);
      wr(`CFS_IX_HB_TO, 32'h3);
      wr(`CFS_IX_AR_TO, 32'h5);
      wr(`CFS_IX_AI_EN, 32'h1);
      wr(`CFS_IX_ISL_MODE, 32'h2);
      wr(`CFS_IX_CTRL, 32'h2);
      rd(`CFS_IX_DC_OC);
      chk(rq, 32'h1f4, "threshold readback");
      meas.i_rms <= {3{16'h00c8}};
      meas.v_ll <= {3{16'h01f4}};
      meas.dc_v <= 16'h01f4;
      meas.dc_i <= 16'h0064;
      meas.rect_v <= 16'h0064;
      meas.link_v <= 16'h0190;
      cw(4);
      clr("setup");
      // Run with contactors, then DC over-current with a reset refused while it lasts
      {run_req, ac_req, ac_closed} <= 3'b111;
      cw(4);
      chk({27'h0, st, pwr_en, ac_cl, dc_cl}, 32'hf, "run");
      meas.dc_i <= 16'h01f5;
      tripped(`CFS_FB_DC_OC, "dc oc");
      wr(`CFS_IX_FLT_RST, 32'h1);
      fault_is(32'h1 << `CFS_FB_DC_OC, "reset refused");
      meas.dc_i <= 16'h0064;
      run_req <= 1'b0;
      clr("dc_oc");
      for (int k = 0; k < 2; k++) begin
         meas.dc_v <= (k == 0) ? 16'h0385 : 16'h0063;
         tripped(`CFS_FB_DC_V, "dc window");
         meas.dc_v <= 16'h01f4;
         clr("dc_v");
      end
      for (int p = 0; p < 3; p++) begin
         meas.i_rms[p] <= 16'h03e9;
         tripped(`CFS_FB_INV_OC, "phase oc");
         meas.i_rms[p] <= 16'h00c8;
         clr("ac_oc");
      end
      ac_closed <= 1'b0;
      meas.v_ll[1] <= 16'h03e9;
      cw(6);
      fault_is(32'h0, "ov contactor open");
      ac_closed <= 1'b1;
      tripped(`CFS_FB_AC_OV, "ac ov");
      meas.v_ll[1] <= 16'h01f4;
      clr("ac_ov");
      emergency_stop_input <= 1'b0;
      tripped(`CFS_FB_EMERGENCY_STOP_INPUT, "emergency_stop_input");
      emergency_stop_input <= 1'b1;
      cw(3);
      clr("emergency_stop_input");
      island <= 1'b1;
      tripped(`CFS_FB_ISLAND, "island");
      island <= 1'b0;
      clr("island");
      wr(`CFS_IX_ISL_MODE, 32'h1);
      island <= 1'b1;
      cw(6);
      fault_is(32'h0, "island other mode");
      island <= 1'b0;
      fsrc <= 32'h8;
      tripped(`CFS_FB_FACTORY, "factory");
      rd(`CFS_IX_FACTORY);
      chk(rq, 32'h8, "factory sources");
      fsrc <= 32'h0;
      clr("factory");
      meas.rect_v <= 16'h0191;
      run_req <= 1'b1;
      tripped(`CFS_FB_FACTORY, "interlock");
      rd(`CFS_IX_FACTORY);
      chk(rq, 32'h1 << `CFS_FF_ILK, "interlock source");
      meas.rect_v <= 16'h0064;
      run_req <= 1'b0;
      clr("interlock");
      // Ride-through: one resume, then every event times out
      run_req <= 1'b1;
      cw(3);
      rt_trip <= 4'h1;
      cw(1);
      rt_trip <= 4'h0;
      cw(3);
      chk({30'h0, st}, 32'h2, "offline");
      grid_ok <= 1'b1;
      cw(4);
      chk({30'h0, st}, 32'h1, "resumed");
      grid_ok <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         rt_trip <= 4'h1 << k;
         cw(1);
         rt_trip <= 4'h0;
         cw(3);
         chk({30'h0, st}, 32'h2, "offline");
         cw(30);
         fault_is(32'h1 << (`CFS_FB_RT_LO + k), "ride-through timeout");
         chk({30'h0, st}, 32'h3, "fault state");
         run_req <= 1'b0;
         clr("ride_through");
         run_req <= 1'b1;
         cw(3);
      end
      wr(`CFS_IX_CTRL, 32'h1);
      cw(3);
      meas.i_rms[2] <= 16'h012d;
      cw(4);
      fault_is(32'h0, "timer counting");
      cw(20);
      fault_is(32'h1 << `CFS_FB_INV_OC, "grid form trip");
      meas.i_rms[2] <= 16'h00c8;
      run_req <= 1'b0;
      clr("grid_form");
      climit <= 1'b1;
      cw(360);
      fault_is(32'h0, "overload early");
      cw(60);
      fault_is(32'h1 << `CFS_FB_OVLD, "overload");
      climit <= 1'b0;
      clr("overload");
      {bias_on, still_pwr} <= 2'b01;
      cw(2020);
      fault_is(32'h1 << `CFS_FB_PWRDN, "power down");
      {bias_on, still_pwr} <= 2'b10;
      cw(3);
      clr("power_down");
      bat_low <= 1'b1;
      cw(4);
      rd(`CFS_IX_WARN);
      chk(rq, 32'h1, "clock warning");
      bat_low <= 1'b0;
      cw(4);
      rd(`CFS_IX_WARN);
      chk(rq, 32'h1, "warning held");
      $display("test warning done");
      repeat (4) begin
         ctrl_u.hb(2'h1);
         cw(2);
      end
      ctrl_u.hb(2'h2);
      fault_is(32'h0, "heartbeat kept");
      repeat (6) ctrl_u.hb(2'h0);
      fault_is(32'h1 << `CFS_FB_HB, "heartbeat stale");
      $display("test heartbeat done");
      wrap_up();
   end
endmodule : cfs_tb_top
`default_nettype wire
